//--- design/ppl_pkg.sv
// constants, modes and states of the parallel passive load port
// assumes a 125 MHz system clock; all counts derive from that rate
package ppl_pkg;

   // system clock rate in MHz
   localparam int unsigned SYS_CLK_MHZ = 125;

   // pin timing in printed units
   localparam int unsigned T_REQ_TO_LOW_NS = 600;
   localparam int unsigned T_STATUS_MIN_US = 268;
   localparam int unsigned T_STATUS_MAX_US = 1506;
   localparam int unsigned T_POR_US = 100;
   localparam int unsigned T_INIT_OSC_MIN_US = 175;
   localparam int unsigned T_INIT_OSC_MAX_US = 437;
   localparam int unsigned T_CLK_MAX_PERIOD_NS = 10;
   localparam int unsigned CLK_PERIODS_TO_UCLK = 4;
   localparam int unsigned UCLK_INIT_PERIODS = 17408;

   // derived cycle counts: least times round up, longest round down
   localparam int unsigned REQ_TO_LOW_CYC = (T_REQ_TO_LOW_NS * SYS_CLK_MHZ) / 1000;
   localparam int unsigned STATUS_MIN_CYC = T_STATUS_MIN_US * SYS_CLK_MHZ;
   localparam int unsigned STATUS_MAX_CYC = T_STATUS_MAX_US * SYS_CLK_MHZ;
   localparam int unsigned POR_CYC = T_POR_US * SYS_CLK_MHZ;
   localparam int unsigned INIT_OSC_CYC = T_INIT_OSC_MIN_US * SYS_CLK_MHZ;
   localparam int unsigned UCLK_DELAY_CYC =
      (CLK_PERIODS_TO_UCLK * T_CLK_MAX_PERIOD_NS * SYS_CLK_MHZ + 999) / 1000;

   // bus width straps
   localparam logic [1:0] MODE_X8 = 2'h0;
   localparam logic [1:0] MODE_X16 = 2'h1;
   localparam logic [1:0] MODE_X32 = 2'h2;

   // option bits carried in the first word of the image
   localparam int unsigned OPT_INIT_DONE_BIT = 0;
   localparam int unsigned OPT_USER_CLK_BIT = 1;

   // widths and defaults
   localparam int unsigned DATA_W = 32;
   localparam int unsigned CNT_W = 20;
   localparam int unsigned WORD_CNT_W = 16;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned IMAGE_BYTES_DEF = 1024;

   // reset values of the pins
   localparam logic STATUS_B_RST = 1'b0;
   localparam logic LOAD_DONE_RST = 1'b0;

   // nine states need four bits
   typedef enum logic [3:0] {
      ST_POR,
      ST_CLEAR,
      ST_LOAD,
      ST_ERR,
      ST_DONE_EDGES,
      ST_INIT_OSC,
      ST_INIT_PRE,
      ST_INIT_UCLK,
      ST_USER
   } ppl_state_t;

endpackage

//--- design/ppl_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset; depth a power of two
`timescale 1ns/1ps
`default_nettype none
module ppl_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [WIDTH-1:0] od;
   } ppl_fifo_st_t;

   ppl_fifo_st_t r_reg;
   ppl_fifo_st_t r_next;
   logic push;
   logic pull;

   // ready reflects the stored count only, so a full fifo honestly refuses
   assign in_ready_o = (r_reg.cnt != (AW + 1)'(DEPTH));
   assign out_valid_o = r_reg.ov;
   assign out_data_o = r_reg.od;

   // the output stage is refilled from storage whenever it is empty or taken
   always_comb begin
      r_next = r_reg;
      push = in_valid_i && in_ready_o;
      pull = 1'b0;
      if (r_reg.ov && out_ready_i) begin
         r_next.ov = 1'b0;
      end
      if (!r_next.ov && (r_reg.cnt != '0)) begin
         r_next.od = r_reg.mem[r_reg.rp];
         r_next.ov = 1'b1;
         r_next.rp = r_reg.rp + 1'b1;
         pull = 1'b1;
      end
      if (push) begin
         r_next.mem[r_reg.wp] = in_data_i;
         r_next.wp = r_reg.wp + 1'b1;
      end
      if (push && !pull) begin
         r_next.cnt = r_reg.cnt + 1'b1;
      end else if (pull && !push) begin
         r_next.cnt = r_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule
`default_nettype wire

//--- design/ppl_loader.sv
// device end of the parallel passive load port, one word per rising clock edge
// assumes the host drives request, config clock and data from outside this
// clock domain; the fabric behind drains loaded words over valid/ready
//
// Notes on behaviour
// - request low in user mode restarts a fresh configuration cycle
// - load-complete and status go low within 600 ns of request falling
// - status stays low at least 268 us, released by 1506 us unless stretched
// - status rises within 1506 us after request returns high
// - status held low through the power-on delay
// - load-complete stays low after power-up and throughout loading
// - bus uses bits 7..0, 15..0 or 31..0 per mode; then user pins
// - one whole data word taken on every rising config clock edge
// - load-complete rises only after the whole image arrived without error
// - config clock ignored once configuration has completed
// - with internal oscillator, user mode 175 to 437 us after load-complete
// - user clock enabled after 4 max clock periods, then 17408 periods
// - once its option is loaded, init-complete pin low until init ends
`timescale 1ns/1ps
`default_nettype none
module ppl_loader
   import ppl_pkg::*;
#(
   parameter int unsigned IMAGE_BYTES = ppl_pkg::IMAGE_BYTES_DEF,
   parameter int unsigned FIFO_WORDS = ppl_pkg::FIFO_DEPTH,
   parameter int unsigned POR_CYCLES = ppl_pkg::POR_CYC,
   parameter int unsigned STATUS_MIN_CYCLES = ppl_pkg::STATUS_MIN_CYC,
   parameter int unsigned INIT_OSC_CYCLES = ppl_pkg::INIT_OSC_CYC,
   parameter int unsigned UCLK_PERIODS = ppl_pkg::UCLK_INIT_PERIODS
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic config_req_b_i,
   input wire logic config_clock_i,
   input wire logic user_supplied_clock_i,
   input wire logic [1:0] width_mode_i,
   input wire logic [ppl_pkg::DATA_W-1:0] data_i,
   output logic status_b_o,
   output logic status_oe_o,
   output logic load_done_o,
   output logic init_done_o,
   output logic init_done_oe_o,
   output logic user_mode_o,
   output logic cfg_valid_o,
   input wire logic cfg_ready_i,
   output logic [ppl_pkg::DATA_W-1:0] cfg_data_o
);
   import ppl_pkg::*;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic clk_s1;
      logic clk_s2;
      logic clk_d;
      logic uck_s1;
      logic uck_s2;
      logic uck_d;
      logic [1:0] mode_s1;
      logic [1:0] mode_s2;
      logic [DATA_W-1:0] dat_s1;
      logic [DATA_W-1:0] dat_s2;
      ppl_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [WORD_CNT_W-1:0] words;
      logic [1:0] mode;
      logic falls;
      logic opt_init;
      logic opt_uclk;
      logic status_b;
      logic status_oe;
      logic load_done;
      logic init_done;
      logic user_mode;
      logic push;
      logic [DATA_W-1:0] push_data;
   } ppl_loader_st_t;

   ppl_loader_st_t r_reg;
   ppl_loader_st_t r_next;
   logic fifo_ready;
   logic clk_rise;
   logic clk_fall;
   logic uck_rise;

   // keep only the lanes that the strap selects
   function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] mode);
      logic [DATA_W-1:0] m;
      m = 32'h0000_00ff;
      if (mode == MODE_X16) begin
         m = 32'h0000_ffff;
      end else if (mode == MODE_X32) begin
         m = 32'hffff_ffff;
      end
      return m;
   endfunction

   // number of words making up the image at the strapped width
   function automatic logic [WORD_CNT_W-1:0] image_words(input logic [1:0] mode);
      logic [WORD_CNT_W-1:0] w;
      w = WORD_CNT_W'(IMAGE_BYTES);
      if (mode == MODE_X16) begin
         w = WORD_CNT_W'(IMAGE_BYTES / 2);
      end else if (mode == MODE_X32) begin
         w = WORD_CNT_W'(IMAGE_BYTES / 4);
      end
      return w;
   endfunction

   // edges are found on the second sync stage only
   assign clk_rise = r_reg.clk_s2 && !r_reg.clk_d;
   assign clk_fall = !r_reg.clk_s2 && r_reg.clk_d;
   assign uck_rise = r_reg.uck_s2 && !r_reg.uck_d;

   // pins come straight from state flops
   assign status_b_o = r_reg.status_b;
   assign status_oe_o = r_reg.status_oe;
   assign load_done_o = r_reg.load_done;
   assign init_done_o = r_reg.init_done;
   assign init_done_oe_o = r_reg.opt_init;
   assign user_mode_o = r_reg.user_mode;

   // loaded words wait here until the fabric takes them
   ppl_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(r_reg.push),
      .in_ready_o(fifo_ready),
      .in_data_i(r_reg.push_data),
      .out_valid_o(cfg_valid_o),
      .out_ready_i(cfg_ready_i),
      .out_data_o(cfg_data_o)
   );

   // next-state logic for the whole loader
   always_comb begin
      r_next = r_reg;
      // two-stage synchronisers for every pin from the host
      r_next.req_s1 = config_req_b_i;
      r_next.req_s2 = r_reg.req_s1;
      r_next.clk_s1 = config_clock_i;
      r_next.clk_s2 = r_reg.clk_s1;
      r_next.clk_d = r_reg.clk_s2;
      r_next.uck_s1 = user_supplied_clock_i;
      r_next.uck_s2 = r_reg.uck_s1;
      r_next.uck_d = r_reg.uck_s2;
      r_next.mode_s1 = width_mode_i;
      r_next.mode_s2 = r_reg.mode_s1;
      r_next.dat_s1 = data_i;
      r_next.dat_s2 = r_reg.dat_s1;
      r_next.push = 1'b0;
      r_next.cnt = r_reg.cnt + 1'b1;

      case (r_reg.st)
         ST_POR: begin
            // status stays low for the whole power-on delay
            r_next.status_b = 1'b0;
            r_next.status_oe = 1'b1;
            r_next.load_done = 1'b0;
            if (r_reg.cnt >= CNT_W'(POR_CYCLES - 1)) begin
               r_next.st = ST_CLEAR;
               r_next.cnt = '0;
            end
         end
         ST_CLEAR: begin
            // saturate so a long request hold cannot wrap the count
            if (r_reg.cnt >= CNT_W'(STATUS_MIN_CYCLES - 1)) begin
               r_next.cnt = r_reg.cnt;
            end
            // release once the least low time passed and request is high
            if (r_reg.cnt >= CNT_W'(STATUS_MIN_CYCLES - 1) && r_reg.req_s2) begin
               r_next.st = ST_LOAD;
               r_next.status_b = 1'b1;
               r_next.status_oe = 1'b0;
               r_next.words = '0;
               r_next.mode = r_reg.mode_s2;
            end
         end
         ST_LOAD: begin
            // a word refused by a full fifo is lost, so the load fails
            if (r_reg.push && !fifo_ready) begin
               r_next.st = ST_ERR;
               r_next.status_b = 1'b0;
               r_next.status_oe = 1'b1;
            end else if (clk_rise) begin
               r_next.push = 1'b1;
               r_next.push_data = r_reg.dat_s2 & lane_mask(r_reg.mode);
               r_next.words = r_reg.words + 1'b1;
               if (r_reg.words == '0) begin
                  r_next.opt_init = r_reg.dat_s2[OPT_INIT_DONE_BIT];
                  r_next.opt_uclk = r_reg.dat_s2[OPT_USER_CLK_BIT];
               end
               if (r_reg.words + 1'b1 == image_words(r_reg.mode)) begin
                  r_next.st = ST_DONE_EDGES;
               end
            end
         end
         ST_DONE_EDGES: begin
            // last word must also be accepted before completion shows
            if (r_reg.push && !fifo_ready) begin
               r_next.st = ST_ERR;
               r_next.status_b = 1'b0;
               r_next.status_oe = 1'b1;
            end else begin
               r_next.load_done = 1'b1;
            end
            // count the two falling edges that start initialisation
            if (r_reg.load_done && clk_fall) begin
               r_next.falls = 1'b1;
               if (r_reg.falls) begin
                  r_next.st = r_reg.opt_uclk ? ST_INIT_PRE : ST_INIT_OSC;
                  r_next.cnt = '0;
               end
            end
         end
         ST_INIT_OSC: begin
            // config clock no longer looked at from here on
            if (r_reg.cnt >= CNT_W'(INIT_OSC_CYCLES - 1)) begin
               r_next.st = ST_USER;
            end
         end
         ST_INIT_PRE: begin
            // wait four worst-case clock periods before using the user clock
            if (r_reg.cnt >= CNT_W'(UCLK_DELAY_CYC - 1)) begin
               r_next.st = ST_INIT_UCLK;
               r_next.cnt = '0;
            end
         end
         ST_INIT_UCLK: begin
            // count user clock rises, not system cycles
            r_next.cnt = r_reg.cnt;
            if (uck_rise) begin
               r_next.cnt = r_reg.cnt + 1'b1;
               if (r_reg.cnt == CNT_W'(UCLK_PERIODS - 1)) begin
                  r_next.st = ST_USER;
               end
            end
         end
         ST_USER: begin
            r_next.cnt = r_reg.cnt;
         end
         ST_ERR: begin
            // status stays low until the host pulses the request
            r_next.cnt = r_reg.cnt;
         end
         default: begin
            r_next.st = ST_POR;
            r_next.cnt = '0;
         end
      endcase

      // entering user mode releases the init-complete pin
      if (r_next.st == ST_USER) begin
         r_next.user_mode = 1'b1;
         r_next.init_done = 1'b1;
      end else begin
         r_next.user_mode = 1'b0;
         r_next.init_done = 1'b0;
      end

      // a low request restarts from any state but power-on, within a few cycles
      if (!r_reg.req_s2 && r_reg.st != ST_POR) begin
         r_next.st = ST_CLEAR;
         r_next.status_b = 1'b0;
         r_next.status_oe = 1'b1;
         r_next.load_done = 1'b0;
         r_next.user_mode = 1'b0;
         r_next.init_done = 1'b0;
         r_next.opt_init = 1'b0;
         r_next.opt_uclk = 1'b0;
         r_next.falls = 1'b0;
         r_next.push = 1'b0;
         if (r_reg.st != ST_CLEAR) begin
            r_next.cnt = '0;
         end
      end
   end

   // single register for all state; pins start in the power-on hold
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r_reg <= '0;
         r_reg.req_s1 <= 1'b1;
         r_reg.req_s2 <= 1'b1;
         r_reg.st <= ST_POR;
         r_reg.status_b <= STATUS_B_RST;
         r_reg.status_oe <= 1'b1;
         r_reg.load_done <= LOAD_DONE_RST;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule
`default_nettype wire

//--- test/ppl_loader_props.sv
// pin-level checker for the load port
// assumes it is bound to ppl_loader and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ppl_loader_props
   import ppl_pkg::*;
#(
   parameter int unsigned STATUS_MIN_CYCLES = 33500,
   parameter int unsigned INIT_OSC_CYCLES = 21875
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic config_req_b_i,
   input wire logic [1:0] width_mode_i,
   input wire logic status_b_o,
   input wire logic status_oe_o,
   input wire logic load_done_o,
   input wire logic init_done_o,
   input wire logic init_done_oe_o,
   input wire logic user_mode_o,
   input wire logic cfg_valid_o,
   input wire logic cfg_ready_i,
   input wire logic [ppl_pkg::DATA_W-1:0] cfg_data_o
);
   logic [31:0] low_cnt_reg, low_cnt_next, done_cnt_reg, done_cnt_next, keep_mask;
   // run lengths of status low and load done high, plus the bus mask
   always_comb begin
      low_cnt_next = status_oe_o ? low_cnt_reg + 32'h1 : 32'h0;
      done_cnt_next = load_done_o ? done_cnt_reg + 32'h1 : 32'h0;
      keep_mask = (width_mode_i == MODE_X8) ? 32'hff :
         ((width_mode_i == MODE_X16) ? 32'hffff : 32'hffffffff);
   end
   // counters clear in reset so the power-on window starts from zero
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         low_cnt_reg <= 32'h0;
         done_cnt_reg <= 32'h0;
      end else begin
         low_cnt_reg <= low_cnt_next;
         done_cnt_reg <= done_cnt_next;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   sequence req_fall_s; $fell(config_req_b_i); endsequence
   sequence cleared_s; status_oe_o && !status_b_o && !load_done_o && !user_mode_o; endsequence
   sequence req_steady_s; config_req_b_i [*4]; endsequence
   chk_req_to_low: assert property (req_fall_s |-> ##[0:4] cleared_s)
      else $error("request fall not answered in time");
   chk_status_min: assert property ($fell(status_oe_o) |-> low_cnt_reg >= STATUS_MIN_CYCLES)
      else $error("status low pulse too short");
   // the release acts on the request as sampled three edges before the fall is seen
   chk_release_req: assert property ($fell(status_oe_o) |-> $past(config_req_b_i, 3))
      else $error("status released while request low");
   chk_done_low: assert property (status_oe_o |-> !load_done_o)
      else $error("load done high while status low");
   chk_fifo_hold: assert property (cfg_valid_o && !cfg_ready_i |=> cfg_valid_o && $stable(cfg_data_o))
      else $error("word dropped while stalled");
   chk_width_mask: assert property (cfg_valid_o |-> (cfg_data_o & ~keep_mask) == 32'h0)
      else $error("data bits outside bus width");
   chk_init_osc: assert property ($rose(user_mode_o) |-> done_cnt_reg >= INIT_OSC_CYCLES)
      else $error("user mode too early");
   chk_user_hold: assert property (req_steady_s ##0 user_mode_o |=> user_mode_o)
      else $error("user mode left without request");
   chk_init_pin: assert property (init_done_oe_o && !user_mode_o |-> !init_done_o)
      else $error("init pin high before user mode");
endmodule
`default_nettype wire

//--- test/ppl_host.sv
// host model driving request, config clock and data
// assumes status_line_i is the pulled-up status wire
`timescale 1ns/1ps
`default_nettype none
module ppl_host (
   input wire logic status_line_i,
   output logic req_b_o,
   output logic cclk_o,
   output logic [31:0] data_o
);
   // idle: request high, clock parked low
   initial begin
      req_b_o = 1'b1;
      cclk_o = 1'b0;
      data_o = 32'h0;
   end
   // request pulse of 2 us; called on a system edge, it moves 2 ns later so that
   // every later host edge, all on multiples of 8 ns, stays clear of the sampling edge
   task automatic restart();
      #2;
      req_b_o = 1'b0;
      #2000;
      req_b_o = 1'b1;
   endtask
   // bounded poll of status, then the settle gap before clocking
   task automatic wait_status(output logic ok);
      int n;
      ok = 1'b0;
      for (n = 0; n < 4000 && !ok; n++) begin
         #8;
         ok = status_line_i;
      end
      #2000;
   endtask
   // one word per 64 ns rise; data moves only while the clock is low
   task automatic word(input logic [31:0] w);
      data_o = w;
      #32;
      cclk_o = 1'b1;
      #32;
      cclk_o = 1'b0;
   endtask
   // idle data shows junk so a stale word is never mistaken for valid
   task automatic park();
      data_o = ~data_o;
   endtask
   // two extra falls after load done
   task automatic finish();
      repeat (2) begin
         #32;
         cclk_o = 1'b1;
         #32;
         cclk_o = 1'b0;
      end
      park();
   endtask
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the parallel load port
// assumes ppl_host as far side and shortened counts below
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
   $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
`define WAITF(nm, c, n) begin for (k = 0; k < (n) && ((c) !== 1'b1); k++) \
   @(negedge clk_sys_i); if ((c) !== 1'b1) begin num_errors++; \
   $display("wrong value %s expected 1 seen 0", nm); end_of_test(); end end
module tb;
   import ppl_pkg::*;
   typedef struct {logic [1:0] mode; logic [31:0] opt;} ppl_row_t;
   localparam int IMG = 32;
   logic clk_sys_i, rst_b_i, uclk, cfg_ready, status_b, status_oe, load_done, ok;
   logic init_done, init_oe, user_mode, cfg_valid, req_b, cclk, status_line;
   logic [1:0] mode;
   logic [31:0] data, cfg_data;
   logic [31:0] got_q[$];
   int num_errors, checks_done, k, r, j;
   ppl_row_t rows[4] = '{'{MODE_X8, 32'h1}, '{MODE_X16, 32'h3}, '{MODE_X32, 32'h2},
      '{MODE_X32, 32'h0}};
   assign status_line = status_oe ? 1'b0 : 1'b1;
   ppl_loader #(.IMAGE_BYTES(IMG), .POR_CYCLES(20), .STATUS_MIN_CYCLES(40),
      .INIT_OSC_CYCLES(30), .UCLK_PERIODS(16)) dut_u (.clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i), .config_req_b_i(req_b), .config_clock_i(cclk),
      .user_supplied_clock_i(uclk), .width_mode_i(mode), .data_i(data), .status_b_o(status_b),
      .status_oe_o(status_oe), .load_done_o(load_done), .init_done_o(init_done),
      .init_done_oe_o(init_oe), .user_mode_o(user_mode), .cfg_valid_o(cfg_valid),
      .cfg_ready_i(cfg_ready), .cfg_data_o(cfg_data));
   ppl_host host_u (.status_line_i(status_line), .req_b_o(req_b), .cclk_o(cclk), .data_o(data));
   // system clock and a free running init clock
   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      uclk = 1'b0;
      forever #20 uclk = ~uclk;
   end
   // fabric side collects every word it accepts
   always @(posedge clk_sys_i) begin
      if (cfg_valid && cfg_ready) got_q.push_back(cfg_data);
   end
   function automatic logic [31:0] pat(input int i, input logic [31:0] opt);
      return (i == 0) ? opt : ({4{i[7:0]}} ^ 32'h3c5a96e1);
   endfunction
   function automatic logic [31:0] mask_of(input logic [1:0] m);
      return (m == MODE_X8) ? 32'hff : ((m == MODE_X16) ? 32'hffff : 32'hffffffff);
   endfunction
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // full image in one width, then init and user mode
   task automatic load(input ppl_row_t rw);
      int i, nw;
      nw = IMG >> rw.mode;
      got_q.delete();
      @(posedge clk_sys_i);
      mode <= rw.mode;
      host_u.restart();
      host_u.wait_status(ok);
      `CHK("status release", 1'b1, ok)
      for (i = 0; i < nw; i++) begin
         if (i == nw - 1) @(negedge clk_sys_i);
         if (i == nw - 1) `CHK("load done early", 1'b0, load_done)
         host_u.word(pat(i, rw.opt));
      end
      `WAITF("load done", load_done, 40)
      host_u.finish();
      `WAITF("user mode", user_mode, 2000)
      repeat (2) @(negedge clk_sys_i);
      `CHK("init pin enable", rw.opt[0], init_oe)
      `CHK("init done", 1'b1, init_done)
      `CHK("word count", nw, got_q.size())
      for (i = 0; i < nw; i++) `CHK("word", pat(i, rw.opt) & mask_of(rw.mode), got_q[i])
   endtask
   initial begin
      rst_b_i = 1'b0;
      cfg_ready = 1'b1;
      mode = MODE_X8;
      num_errors = 0;
      checks_done = 0;
      repeat (12) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK("reset status", 1'b1, status_oe)
      `CHK("reset status pin", 1'b0, status_b)
      `CHK("reset load done", 1'b0, load_done)
      @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      repeat (10) @(negedge clk_sys_i);
      `CHK("power-on status", 1'b1, status_oe)
      for (r = 0; r < 4; r++) load(rows[r]);
      // clock activity in user mode must be ignored
      for (j = 0; j < 3; j++) host_u.word(32'h5a5a5a5a);
      host_u.park();
      @(negedge clk_sys_i);
      `CHK("user mode kept", 1'b1, user_mode)
      `CHK("no word taken", 1'b0, cfg_valid)
      @(posedge clk_sys_i);
      fork
         host_u.restart();
         begin
            repeat (6) @(negedge clk_sys_i);
            `CHK("restart status", 1'b1, status_oe)
            `CHK("restart user mode", 1'b0, user_mode)
         end
      join
      // stalled fabric in x8, so the image outlasts the fifo: the output stage
      // and eight stored words fill up, the tenth word overflows
      @(posedge clk_sys_i);
      cfg_ready <= 1'b0;
      mode <= MODE_X8;
      host_u.restart();
      host_u.wait_status(ok);
      for (j = 0; j < 9; j++) host_u.word(j);
      @(negedge clk_sys_i);
      `CHK("status while full", 1'b0, status_oe)
      host_u.word(32'h99);
      host_u.park();
      `WAITF("overflow status", status_oe, 8)
      `CHK("no load done", 1'b0, load_done)
      @(posedge clk_sys_i);
      cfg_ready <= 1'b1;
      `WAITF("drained", !cfg_valid, 20)
      load(rows[0]);
      end_of_test();
   end
endmodule
bind ppl_loader ppl_loader_props #(.STATUS_MIN_CYCLES(STATUS_MIN_CYCLES),
   .INIT_OSC_CYCLES(INIT_OSC_CYCLES)) props_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
   .config_req_b_i(config_req_b_i), .width_mode_i(width_mode_i), .status_b_o(status_b_o),
   .status_oe_o(status_oe_o), .load_done_o(load_done_o), .init_done_o(init_done_o),
   .init_done_oe_o(init_done_oe_o), .user_mode_o(user_mode_o), .cfg_valid_o(cfg_valid_o),
   .cfg_ready_i(cfg_ready_i), .cfg_data_o(cfg_data_o));
`default_nettype wire
